// ### dmx_arbiter.sv
// How it works
// - Address mux follows the timing controller, switching to X/Y only during grant.
// - Refresh reads happen in cell clock high phase; their data is latched except during grab/preset.
// - External accesses wait for the cell clock low phase, then get granted.
// - Grant is triggered by select strobe trailing edge or vector write request with the vector write flag set.
// - Overflow outside a DMA transfer suppresses the grant, so no external access happens.
// - Overflow is never flagged while a DMA transfer is running.
// - Writes enabled by timed strobe for grab/preset, synced host write otherwise.
// - Sixteen active-low write lines, RAM picked by the two pixel low bits on synced host writes, all four RAMs on the timed strobe.
// - A low plane allow line blocks every write to that plane.
// - Refresh row bits zero to three and seven come from the low part of the controller address.
// - Row bits four to six pick scan line bits by Y zoom.
// - At large X zoom an extra cycle follows each refresh read, force bits high.
// - With 64K RAMs row bit seven and column bit two swap places.
// - Cell clock steps once per eight divided clock ticks, clock divided by X zoom plus one.
// - Two reads per high phase, column select low then high.
`timescale 1ns/10ps
`default_nettype none
`include "dmx_cfg.svh"
module dmx_arbiter import dmx_pkg::*; #(
  parameter int PLANES = `DMX_PLANES,
  parameter logic [2:0] ZOOM_REF_MIN = `DMX_ZOOM_REF_MIN
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic [2:0] XZOOM_I,
  input wire logic [1:0] YZOOM_I,
  input wire logic RAM64K_I,
  input wire logic MEM_OP_I,
  input wire logic [`DMX_MA_W-1:0] CRTC_ADDR_I,
  input wire logic [4:0] SCAN_LINE_COUNT_I,
  input wire dmx_pix_s PIXEL_ADDR_I,
  input wire logic HOST_SEL_N_I,
  input wire logic HOST_WR_N_I,
  input wire logic VECTOR_WRITE_REQUEST_N_I,
  input wire logic VECTOR_WRITE_FLAG_I,
  input wire logic X_OVF_I,
  input wire logic Y_OVF_I,
  input wire logic DMA_ACTIVE_I,
  input wire logic [PLANES-1:0] PLANE_ALLOW_I,
  input wire logic [PLANES*4-1:0] DISP_DATA_I,
  output logic CELL_CLOCK_O,
  output logic COL_SEL_O,
  output logic DISP_READ_O,
  output logic EXTRA_REFRESH_O,
  output logic [PLANES*4-1:0] DISP_LATCH0_O,
  output logic [PLANES*4-1:0] DISP_LATCH1_O,
  output dmx_addr_s MEM_ADDR_O,
  output logic BUS_ACCESS_GRANT_O,
  output logic OVERFLOW_N_A_O,
  output logic XFER_ACK_O,
  output logic TIMED_WRITE_STROBE_N_O,
  output logic SYNCED_HOST_WRITE_N_O,
  output logic [PLANES*4-1:0] RAM_WRITE_LINES_O
);
  // ---------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic rst_meta_r, rst_n_r;
  logic [6:0] sync1_r, sync2_r;
  logic sel_prev_r, vec_prev_r;
  logic sel_s, wr_s, vreq_s, vflag_s, ovf_s, dma_s;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sync1_r <= 7'h0f;
      sync2_r <= 7'h0f;
      sel_prev_r <= 1'b1;
      vec_prev_r <= 1'b0;
    end else begin
      sync1_r <= {X_OVF_I | Y_OVF_I, DMA_ACTIVE_I, VECTOR_WRITE_FLAG_I, 1'b0,
                  VECTOR_WRITE_REQUEST_N_I, HOST_WR_N_I, HOST_SEL_N_I};
      sync2_r <= sync1_r;
      sel_prev_r <= sel_s;
      vec_prev_r <= ~vreq_s & vflag_s;
    end
  end

  assign sel_s = sync2_r[0];
  assign wr_s = sync2_r[1];
  assign vreq_s = sync2_r[2];
  assign vflag_s = sync2_r[4];
  assign dma_s = sync2_r[5];
  assign ovf_s = sync2_r[6];

  // ---------------------------------------------------------------
  // Cell clock timing
  // ---------------------------------------------------------------
  logic [2:0] div_cnt_r, phase_r;
  logic tick;

  assign tick = (div_cnt_r == XZOOM_I);

  always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_cnt_r <= 3'h0;
      phase_r <= 3'h0;
    end else begin
      div_cnt_r <= tick ? 3'h0 : div_cnt_r + 3'h1;
      if (tick) begin
        phase_r <= phase_r + 3'h1;
      end
    end
  end

  logic high_phase, large_zoom, extra_cyc, read_slot;
  assign high_phase = phase_r[2];
  assign large_zoom = (XZOOM_I >= ZOOM_REF_MIN);
  assign read_slot = high_phase && !phase_r[0];
  assign extra_cyc = high_phase && phase_r[0] && large_zoom;
  assign CELL_CLOCK_O = high_phase;
  assign COL_SEL_O = high_phase & phase_r[1];
  assign DISP_READ_O = read_slot && (div_cnt_r == 3'h0);
  assign EXTRA_REFRESH_O = extra_cyc && (div_cnt_r == 3'h0);

  always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      DISP_LATCH0_O <= '0;
      DISP_LATCH1_O <= '0;
    end else if (DISP_READ_O && !MEM_OP_I) begin
      if (phase_r[1]) begin
        DISP_LATCH1_O <= DISP_DATA_I;
      end else begin
        DISP_LATCH0_O <= DISP_DATA_I;
      end
    end
  end

  // ---------------------------------------------------------------
  // External access arbitration
  // ---------------------------------------------------------------
  dmx_arb_e state_r;
  logic req_wr_r, trigger, low_start, low_end, overflow_n_a;

  assign trigger = (sel_s && !sel_prev_r) || (!vreq_s && vflag_s && !vec_prev_r);
  assign low_start = tick && (phase_r == `DMX_PH_LAST);
  assign low_end = tick && (phase_r == `DMX_PH_LOW_LAST);
  assign overflow_n_a = ovf_s && !dma_s;
  assign OVERFLOW_N_A_O = ~overflow_n_a;

  always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= DMX_IDLE;
    end else begin
      case (state_r)
        DMX_IDLE: begin
          if (trigger) begin
            state_r <= DMX_WAIT;
          end
        end
        DMX_WAIT: begin
          if (low_start) begin
            state_r <= overflow_n_a ? DMX_IDLE : DMX_GRANT;
          end
        end
        DMX_GRANT: begin
          if (low_end) begin
            state_r <= DMX_IDLE;
          end
        end
        default: begin
          state_r <= DMX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      req_wr_r <= 1'b0;
    end else if (state_r == DMX_IDLE && trigger) begin
      req_wr_r <= !(sel_s && !sel_prev_r) || !wr_s;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      XFER_ACK_O <= 1'b0;
    end else begin
      XFER_ACK_O <= (state_r == DMX_GRANT && low_end) || (state_r == DMX_WAIT && low_start && overflow_n_a);
    end
  end

  assign BUS_ACCESS_GRANT_O = (state_r == DMX_GRANT);

  // ---------------------------------------------------------------
  // Address formation
  // ---------------------------------------------------------------
  function automatic logic [2:0] dmx_scan_bits(input logic [4:0] ra, input logic [1:0] yz);
    logic [2:0] b;
    b = 3'h0;
    case (yz)
      2'h0: b = ra[2:0];
      2'h1: b = ra[3:1];
      default: b = ra[4:2];
    endcase
    return b;
  endfunction : dmx_scan_bits

  dmx_addr_s ref_addr, ext_addr;
  logic force_ref;

  always_comb begin
    force_ref = extra_cyc;
    ref_addr.row = {CRTC_ADDR_I[4], dmx_scan_bits(SCAN_LINE_COUNT_I, YZOOM_I), CRTC_ADDR_I[3:0]};
    ref_addr.col = {CRTC_ADDR_I[11:7], CRTC_ADDR_I[6] | force_ref, CRTC_ADDR_I[5] | force_ref, COL_SEL_O};
    if (RAM64K_I) begin
      ref_addr.row[7] = CRTC_ADDR_I[6] | force_ref;
      ref_addr.col[2] = CRTC_ADDR_I[4];
    end
    ext_addr.row = PIXEL_ADDR_I.y[7:0];
    ext_addr.col = {PIXEL_ADDR_I.y[8], PIXEL_ADDR_I.x[8:2]};
  end

  always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      MEM_ADDR_O <= '0;
    end else begin
      MEM_ADDR_O <= BUS_ACCESS_GRANT_O ? ext_addr : ref_addr;
    end
  end

  // ---------------------------------------------------------------
  // Write enables
  // ---------------------------------------------------------------
  // write strobe sources
  assign TIMED_WRITE_STROBE_N_O = ~(MEM_OP_I && read_slot && !BUS_ACCESS_GRANT_O);
  assign SYNCED_HOST_WRITE_N_O = ~(BUS_ACCESS_GRANT_O && req_wr_r && phase_r == `DMX_PH_HOST_WR);

  dmx_we_decoder #(.PLANES(PLANES)) u_we (
    .clk_i(CLOCK_I),
    .rst_n_i(rst_n_r),
    .enable_n_i(TIMED_WRITE_STROBE_N_O & SYNCED_HOST_WRITE_N_O),
    .all_rams_i(!SYNCED_HOST_WRITE_N_O ? 1'b0 : 1'b1),
    .pixel_low_bit_zero_i(PIXEL_ADDR_I.x[0]),
    .pixel_low_bit_one_i(PIXEL_ADDR_I.x[1]),
    .plane_allow_i(PLANE_ALLOW_I),
    .ram_write_lines_o(RAM_WRITE_LINES_O)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_GRANT_LOW: assert property (@(posedge CLOCK_I) disable iff (!rst_n_r)
    BUS_ACCESS_GRANT_O |-> !CELL_CLOCK_O) else $error("grant outside low phase");
  AST_GRANT_START: assert property (@(posedge CLOCK_I) disable iff (!rst_n_r)
    $rose(BUS_ACCESS_GRANT_O) |-> phase_r == 3'h0 && $past(phase_r) == 3'h7) else $error("grant late");
  AST_NO_OVERFLOW_N_A_GRANT: assert property (@(posedge CLOCK_I) disable iff (!rst_n_r)
    (state_r == DMX_WAIT && low_start && overflow_n_a) |=> !BUS_ACCESS_GRANT_O) else $error("grant despite overflow");
  AST_DMA_NO_OVF: assert property (@(posedge CLOCK_I) disable iff (!rst_n_r)
    dma_s |-> OVERFLOW_N_A_O) else $error("overflow during dma");
  AST_TRIGGER: assert property (@(posedge CLOCK_I) disable iff (!rst_n_r)
    (state_r == DMX_IDLE && sel_s && !sel_prev_r) |=> state_r == DMX_WAIT) else $error("trigger lost");
  AST_ACK_AFTER: assert property (@(posedge CLOCK_I) disable iff (!rst_n_r)
    (BUS_ACCESS_GRANT_O && low_end) |=> XFER_ACK_O && !BUS_ACCESS_GRANT_O) else $error("ack missing");
  AST_MUX_EXT: assert property (@(posedge CLOCK_I) disable iff (!rst_n_r)
    BUS_ACCESS_GRANT_O |=> MEM_ADDR_O.row == $past(PIXEL_ADDR_I.y[7:0])) else $error("mux not external");
  AST_READ_HIGH: assert property (@(posedge CLOCK_I) disable iff (!rst_n_r)
    DISP_READ_O |-> CELL_CLOCK_O && (COL_SEL_O == phase_r[1])) else $error("read outside high phase");
  AST_WR_PLANE: assert property (@(posedge CLOCK_I) disable iff (!rst_n_r)
    !PLANE_ALLOW_I[0] |=> RAM_WRITE_LINES_O[3:0] == 4'hf) else $error("blocked plane written");
  AST_CELL_PERIOD: assert property (@(posedge CLOCK_I) disable iff (!rst_n_r)
    ($rose(CELL_CLOCK_O) && XZOOM_I == 3'h0 && $past(XZOOM_I, 8) == 3'h0 && $past(XZOOM_I, 16) == 3'h0 &&
     $past(rst_n_r, 16)) |-> (!$past(CELL_CLOCK_O, 4) && $past(CELL_CLOCK_O, 5) && $past(CELL_CLOCK_O, 8) &&
     !$past(CELL_CLOCK_O, 9)))
    else $error("cell clock period wrong");
endmodule : dmx_arbiter
`default_nettype wire

// ### dmx_cfg.svh
`ifndef DMX_CFG_SVH
`define DMX_CFG_SVH
`define DMX_CLK_PERIOD_NS 50
`define DMX_PH_LAST 3'h7
`define DMX_PH_LOW_LAST 3'h3
`define DMX_PH_HOST_WR 3'h1
`define DMX_PH_READ0 3'h4
`define DMX_PH_READ1 3'h6
`define DMX_ZOOM_REF_MIN 3'h3
`define DMX_PLANES 4
`define DMX_RAMS_PER_PLANE 4
`define DMX_ADDR_W 16
`define DMX_MA_W 14
`define DMX_PIX_W 9
`endif

// ### dmx_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmx_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  output logic sel_n_o,
  output logic wr_n_o
);
  initial begin
    sel_n_o = 1'b1;
    wr_n_o = 1'b1;
  end

  // ----
  // Bus cycle
  // ----
  // The write level stays put until the acknowledge, then shows the inverse.
  task automatic access(input logic wr, input int hold, output logic acked);
    acked = 1'b0;
    @(negedge clk_i);
    sel_n_o = 1'b0;
    wr_n_o = ~wr;
    repeat (hold) @(negedge clk_i);
    sel_n_o = 1'b1;
    for (int i = 0; i < 60 && !acked; i++) begin
      @(negedge clk_i);
      acked = (ack_i === 1'b1);
    end
    wr_n_o = wr;
  endtask : access
endmodule : dmx_host_model
`default_nettype wire

// ### dmx_pkg.sv
package dmx_pkg;
  typedef enum logic [1:0] {DMX_IDLE, DMX_WAIT, DMX_GRANT} dmx_arb_e;
  typedef struct packed {
    logic [8:0] y;
    logic [8:0] x;
  } dmx_pix_s;
  typedef struct packed {
    logic [7:0] col;
    logic [7:0] row;
  } dmx_addr_s;
endpackage : dmx_pkg

// ### dmx_we_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmx_cfg.svh"
module dmx_we_decoder import dmx_pkg::*; #(
  parameter int PLANES = `DMX_PLANES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_n_i,
  input wire logic all_rams_i,
  input wire logic pixel_low_bit_zero_i,
  input wire logic pixel_low_bit_one_i,
  input wire logic [PLANES-1:0] plane_allow_i,
  output logic [PLANES*4-1:0] ram_write_lines_o
);
  logic [PLANES*4-1:0] lines_nxt;

  always_comb begin
    lines_nxt = '1;
    for (int p = 0; p < PLANES; p++) begin
      for (int r = 0; r < 4; r++) begin
        if (!enable_n_i && plane_allow_i[p] &&
            (all_rams_i || (r == {30'h0, pixel_low_bit_one_i, pixel_low_bit_zero_i}))) begin
          lines_nxt[p*4+r] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_write_lines_o <= '1;
    end else begin
      ram_write_lines_o <= lines_nxt;
    end
  end
endmodule : dmx_we_decoder
`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmx_cfg.svh"
module tb import dmx_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, mem_op = 1'b0, ram64 = 1'b0, vreq_n = 1'b1, vflag = 1'b0;
  logic xovf = 1'b0, yovf = 1'b0, dma = 1'b0, cc_q = 1'b0;
  logic [2:0] xz = 3'h0;
  logic [1:0] yz = 2'h0;
  logic [13:0] ma = 14'h0d93;
  logic [4:0] scan = 5'h16;
  logic [3:0] allow = 4'hf;
  logic [15:0] data = 16'h5a3c, seen = 16'hffff, exp_l, lines, latch0, latch1;
  logic sel_n, wr_n, cell_clock, csel, rd, ext, gnt, ovf_n, ack, tws_n, shw_n, ok;
  dmx_pix_s pix = '0;
  dmx_addr_s addr, addr_g;
  int failures = 0, checks_done = 0, cyc = 0, per = 0, gnt_n = 0, ext_n = 0;
  int tws = 0, shw = 0, rd_n = 0, tick = 0, sh = 0;

  always #(`DMX_CLK_PERIOD_NS / 2) clk = ~clk;

  dmx_arbiter dmx_arbiter_i (.CLOCK_I(clk), .RST_N_I(rst_n), .XZOOM_I(xz), .YZOOM_I(yz), .RAM64K_I(ram64),
    .MEM_OP_I(mem_op), .CRTC_ADDR_I(ma), .SCAN_LINE_COUNT_I(scan), .PIXEL_ADDR_I(pix), .HOST_SEL_N_I(sel_n),
    .HOST_WR_N_I(wr_n), .VECTOR_WRITE_REQUEST_N_I(vreq_n), .VECTOR_WRITE_FLAG_I(vflag), .X_OVF_I(xovf),
    .Y_OVF_I(yovf), .DMA_ACTIVE_I(dma), .PLANE_ALLOW_I(allow), .DISP_DATA_I(data), .CELL_CLOCK_O(cell_clock),
    .COL_SEL_O(csel), .DISP_READ_O(rd), .EXTRA_REFRESH_O(ext), .DISP_LATCH0_O(latch0),
    .DISP_LATCH1_O(latch1), .MEM_ADDR_O(addr), .BUS_ACCESS_GRANT_O(gnt), .OVERFLOW_N_A_O(ovf_n),
    .XFER_ACK_O(ack), .TIMED_WRITE_STROBE_N_O(tws_n), .SYNCED_HOST_WRITE_N_O(shw_n),
    .RAM_WRITE_LINES_O(lines));
  dmx_host_model dmx_host_model_i (.clk_i(clk), .ack_i(ack), .sel_n_o(sel_n), .wr_n_o(wr_n));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic xfer(input logic wr, input int exp_g, input logic [15:0] exp_s);
    seen = 16'hffff;
    gnt_n = 0;
    shw = 0;
    dmx_host_model_i.access(wr, 2, ok);
    chk(ok, 1'b1);
    chk(gnt_n, exp_g);
    chk(seen, exp_s);
    chk(shw, (exp_g != 0) && wr);
  endtask : xfer

  // ----
  // Monitor
  // ----
  // Sampled on the falling edge so that registered outputs have settled.
  always @(negedge clk) begin
    tick++;
    if (tick == 30000) begin
      failures++;
      final_report();
    end
    cc_q <= cell_clock;
    cyc <= (cell_clock && !cc_q) ? 1 : cyc + 1;
    if (cell_clock && !cc_q) per <= cyc;
    seen = seen & lines;
    if (ext === 1'b1) ext_n++;
    if (tws_n === 1'b0) tws++;
    if (shw_n === 1'b0) shw++;
    if (gnt === 1'b1) begin
      gnt_n++;
      addr_g <= addr;
      chk(cell_clock, 1'b0);
    end
    if (rd === 1'b1) begin
      chk({cell_clock, csel}, {1'b1, rd_n[0]});
      rd_n++;
    end
  end

  // ----
  // Sequence
  // ----
  initial begin
    repeat (8) @(negedge clk);
    chk({gnt, ack, cell_clock}, 3'h0);
    chk(lines, 16'hffff);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      pix = {9'h1c3, 7'h55, k[1:0]};
      allow = 4'hf ^ (4'h1 << k);
      exp_l = 16'hffff;
      for (int p = 0; p < 4; p++) if (allow[p]) exp_l[p * 4 + k] = 1'b0;
      xfer(1'b1, 4, exp_l);
      chk(addr_g, {pix.y[8], pix.x[8:2], pix.y[7:0]});
    end
    xfer(1'b0, 4, 16'hffff);
    for (int f = 1; f >= 0; f--) begin
      seen = 16'hffff;
      gnt_n = 0;
      vflag = f[0];
      vreq_n = 1'b0;
      repeat (4) @(negedge clk);
      vreq_n = 1'b1;
      for (int i = 0; i < 40 && ack !== 1'b1; i++) @(negedge clk);
      chk(gnt_n, 4 * f);
      chk(seen, f ? exp_l : 16'hffff);
      repeat (2) @(negedge clk);
    end
    for (int i = 0; i < 2; i++) begin
      {xovf, yovf, dma} = i ? 3'b011 : 3'b100;
      repeat (4) @(negedge clk);
      chk(ovf_n, i[0]);
      xfer(1'b1, 4 * i, i ? exp_l : 16'hffff);
    end
    {xovf, yovf, dma} = 3'b000;
    chk({latch0, latch1}, {2{16'h5a3c}});
    mem_op = 1'b1;
    data = 16'h0f0f;
    allow = 4'h5;
    seen = 16'hffff;
    tws = 0;
    repeat (16) @(negedge clk);
    chk(seen, 16'hf0f0);
    chk(tws != 0, 1'b1);
    mem_op = 1'b0;
    allow = 4'hf;
    for (int i = 0; i < 4; i++) begin
      yz = i[1:0];
      repeat (10) @(negedge clk);
      sh = (i > 2) ? 2 : i;
      chk(addr.row, {ma[4], scan[sh +: 3], ma[3:0]});
    end
    chk(addr.col[7:1], {ma[11:7], ma[6:5]});
    ram64 = 1'b1;
    repeat (10) @(negedge clk);
    chk({addr.row[7], addr.col[2]}, {ma[6], ma[4]});
    ram64 = 1'b0;
    for (int z = 0; z < 8; z++) begin
      xz = z[2:0];
      ext_n = 0;
      repeat (200) @(negedge clk);
      chk(per, 8 * (z + 1));
      chk(ext_n != 0, z >= 3);
    end
    for (int i = 0; i < 200 && ext !== 1'b1; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk(addr.col[2:1], 2'b11);
    final_report();
  end
endmodule : tb
`default_nettype wire
